// [src/chan_clk_pkg.sv]
package chan_clk_pkg;

    // Channel count of one transceiver block and width of a fabric word
    localparam int        num_chan    = 4;
    localparam int        word_w      = 8;
    localparam int        num_src     = 8;
    localparam int        ptr_w       = 2;

    // Operation modes
    localparam logic [1:0] mode_tx_only = 2'h0;
    localparam logic [1:0] mode_rx_only = 2'h1;
    localparam logic [1:0] mode_tx_rx   = 2'h2;

    // Package classes
    localparam logic [1:0] pkg_small = 2'h0;
    localparam logic [1:0] pkg_f484  = 2'h1;
    localparam logic [1:0] pkg_large = 2'h2;

    // Clock sources, one index per PLL
    localparam logic [2:0] src_adjacent_pll_a_small_pkg = 3'h0;
    localparam logic [2:0] src_adjacent_pll_b_small_pkg = 3'h1;
    localparam logic [2:0] src_adjacent_pll_a_block0    = 3'h2;
    localparam logic [2:0] src_adjacent_pll_b_block0    = 3'h3;
    localparam logic [2:0] src_adjacent_pll_a_block1    = 3'h4;
    localparam logic [2:0] src_adjacent_pll_b_block1    = 3'h5;
    localparam logic [2:0] src_general_pll_one          = 3'h6;
    localparam logic [2:0] src_general_pll_two          = 3'h7;

    // Reset values of the static configuration
    localparam logic [1:0] rst_mode  = mode_tx_only;
    localparam logic [2:0] rst_src   = src_adjacent_pll_a_small_pkg;
    localparam logic [1:0] rst_pkg   = pkg_small;

    // Channel states, Gray along config -> run -> fault
    typedef enum logic [1:0] {
        st_config = 2'h0,
        st_run    = 2'h1,
        st_fault  = 2'h3
    } chan_state_t;

    // Which PLL may reach which channel; the extra PLLs reach only some channels
    function automatic logic source_legal(input logic [1:0] pkg, input logic blk,
                                          input logic [1:0] ch, input logic [2:0] src);
        logic lo;
        logic ok;
        lo = (ch < 2'h2);
        ok = 1'b0;
        if (pkg == pkg_small) begin
            ok = !blk && (src == src_adjacent_pll_a_small_pkg || src == src_adjacent_pll_b_small_pkg);
        end else if (pkg == pkg_f484 || pkg == pkg_large) begin
            if (!blk && lo) begin
                ok = src == src_adjacent_pll_a_block0 || src == src_general_pll_one
                     || src == src_adjacent_pll_b_block0;
            end else if (!blk) begin
                ok = src == src_adjacent_pll_a_block0 || src == src_adjacent_pll_b_block0
                     || (src == src_adjacent_pll_a_block1 && pkg == pkg_large);
            end else if (pkg == pkg_large && lo) begin
                ok = src == src_adjacent_pll_a_block1 || src == src_adjacent_pll_b_block0
                     || src == src_adjacent_pll_b_block1;
            end else if (pkg == pkg_large) begin
                ok = src == src_adjacent_pll_a_block1 || src == src_adjacent_pll_b_block1
                     || src == src_general_pll_two;
            end
        end
        return ok;
    endfunction : source_legal

    // Divide-by-two of a tick stream: pass every other tick
    function automatic logic halve_tick(input logic enable, input logic tick, input logic phase);
        return enable ? (tick & phase) : tick;
    endfunction : halve_tick

endpackage : chan_clk_pkg

// [src/chan_clk_if.sv]
`timescale 1ns/1ps
interface chan_clk_if;
    logic [3:0]      tx_clkout;
    logic [3:0]      rx_clkout;
    logic [3:0]      rx_on_tx_clk;
    logic [3:0][7:0] rx_word;
    logic [3:0][7:0] tx_word;
    logic [3:0]      tx_launch;

    modport device_end (
        output tx_clkout,
        output rx_clkout,
        output rx_on_tx_clk,
        output rx_word,
        input  tx_word,
        input  tx_launch
    );

    modport fabric_end (
        input  tx_clkout,
        input  rx_clkout,
        input  rx_on_tx_clk,
        input  rx_word,
        output tx_word,
        output tx_launch
    );
endinterface : chan_clk_if

// [src/nonbonded_channel_clocking.sv]
`timescale 1ns/1ps
module nonbonded_channel_clocking (
    input  wire logic                  clock,
    input  wire logic                  reset,
    chan_clk_if.device_end             link,
    input  wire logic [1:0]            cfg_pkg,
    input  wire logic                  cfg_block,
    input  wire logic [3:0][1:0]       cfg_mode,
    input  wire logic [3:0][2:0]       cfg_src,
    input  wire logic [3:0]            cfg_byte_ser,
    input  wire logic [3:0]            cfg_byte_deser,
    input  wire logic [3:0]            cfg_rmf,
    input  wire logic [3:0]            cfg_load,
    input  wire logic [3:0]            run,
    input  wire logic [7:0]            pll_fast_tick,
    input  wire logic [7:0]            pll_slow_tick,
    input  wire logic [3:0]            cdr_fast_tick,
    input  wire logic [3:0]            cdr_slow_tick,
    input  wire logic [3:0][7:0]       rx_data_in,
    output logic      [3:0]            ser_tick,
    output logic      [3:0]            tx_pcs_tick,
    output logic      [3:0]            tx_fifo_rd_tick,
    output logic      [3:0]            deser_tick,
    output logic      [3:0]            align_tick,
    output logic      [3:0]            rmf_wr_tick,
    output logic      [3:0]            rx_pcs_tick,
    output logic      [3:0]            rx_fifo_wr_tick,
    output logic      [3:0][1:0]       tx_fifo_rd_ptr,
    output logic      [3:0][1:0]       rx_fifo_wr_ptr,
    output logic      [3:0][7:0]       tx_word_seen,
    output logic      [3:0]            chan_running,
    output logic      [3:0]            cfg_fault
);

    localparam int n = chan_clk_pkg::num_chan;

    // Static configuration: package and block shared by all channels, the rest one copy per channel
    logic [1:0]                 pkg_q,   pkg_d;
    logic                       blk_q,   blk_d;
    logic [3:0][1:0]            mode_q,  mode_d;
    logic [3:0][2:0]            src_q,   src_d;
    logic [3:0]                 bser_q,  bser_d;
    logic [3:0]                 bdes_q,  bdes_d;
    logic [3:0]                 rmf_q,   rmf_d;
    chan_clk_pkg::chan_state_t  state_q [n];
    chan_clk_pkg::chan_state_t  state_d [n];

    // Divider phases and FIFO pointers
    logic [3:0]                 tx_ph_q, tx_ph_d;
    logic [3:0]                 rx_ph_q, rx_ph_d;
    logic [3:0][1:0]            rd_ptr_q, rd_ptr_d;
    logic [3:0][1:0]            wr_ptr_q, wr_ptr_d;
    logic [3:0][7:0]            seen_q,  seen_d;
    logic [3:0][7:0]            rxw_q,   rxw_d;

    // Registered clock strobes
    logic [3:0]                 ser_q, ser_d, txp_q, txp_d, txr_q, txr_d, des_q, des_d;
    logic [3:0]                 aln_q, aln_d, rmw_q, rmw_d, rxp_q, rxp_d, rxw_tk_q, rxw_tk_d;
    logic [3:0]                 rxclk_q, rxclk_d, ontx_q, ontx_d;
    // State decodes kept in flops so the status outputs never glitch
    logic [3:0]                 run_q, run_d, flt_q, flt_d;

    // Per-channel next state; no channel reads another channel's state
    always_comb begin
        logic legal;
        logic tx_used;
        logic rx_used;
        logic live;
        logic fast;
        logic slow;
        logic rx_base;
        legal   = 1'b0;
        tx_used = 1'b0;
        rx_used = 1'b0;
        live    = 1'b0;
        fast    = 1'b0;
        slow    = 1'b0;
        rx_base = 1'b0;
        pkg_d   = pkg_q;
        blk_d   = blk_q;
        mode_d  = mode_q;
        src_d   = src_q;
        bser_d  = bser_q;
        bdes_d  = bdes_q;
        rmf_d   = rmf_q;
        for (int i = 0; i < n; i++) begin
            state_d[i] = state_q[i];
            // Loads only land while stopped, so a running channel never sees a change
            if (state_q[i] == chan_clk_pkg::st_config && cfg_load[i]) begin
                mode_d[i] = cfg_mode[i];
                src_d[i]  = cfg_src[i];
                bser_d[i] = cfg_byte_ser[i];
                bdes_d[i] = cfg_byte_deser[i];
                rmf_d[i]  = cfg_rmf[i];
                pkg_d     = cfg_pkg;
                blk_d     = cfg_block;
            end
            tx_used = mode_q[i] != chan_clk_pkg::mode_rx_only;
            rx_used = mode_q[i] != chan_clk_pkg::mode_tx_only;
            // Rate match only with both directions; unsupported pairings fault
            legal = mode_q[i] != 2'h3
                    && !(rmf_q[i] && mode_q[i] != chan_clk_pkg::mode_tx_rx)
                    && (!tx_used || chan_clk_pkg::source_legal(pkg_q, blk_q, 2'(i), src_q[i]));
            case (state_q[i])
                chan_clk_pkg::st_config: begin
                    if (run[i] && !cfg_load[i]) begin
                        state_d[i] = legal ? chan_clk_pkg::st_run : chan_clk_pkg::st_fault;
                    end
                end
                chan_clk_pkg::st_run: begin
                    if (!run[i]) begin
                        state_d[i] = chan_clk_pkg::st_config;
                    end
                end
                chan_clk_pkg::st_fault: begin
                    if (!run[i]) begin
                        state_d[i] = chan_clk_pkg::st_config;
                    end
                end
                default: begin
                    state_d[i] = chan_clk_pkg::st_config;
                end
            endcase
        end
        for (int i = 0; i < n; i++) begin
            live    = state_q[i] == chan_clk_pkg::st_run;
            run_d[i] = state_d[i] == chan_clk_pkg::st_run;
            flt_d[i] = state_d[i] == chan_clk_pkg::st_fault;
            tx_used = live && mode_q[i] != chan_clk_pkg::mode_rx_only;
            rx_used = live && mode_q[i] != chan_clk_pkg::mode_tx_only;
            // One source select serves both rates of the channel
            fast    = tx_used && pll_fast_tick[src_q[i]];
            slow    = tx_used && pll_slow_tick[src_q[i]];
            ser_d[i] = fast;
            txp_d[i] = slow;
            tx_ph_d[i] = !live ? 1'b0 : (slow ? ~tx_ph_q[i] : tx_ph_q[i]);
            txr_d[i] = chan_clk_pkg::halve_tick(bser_q[i], slow, tx_ph_q[i]);
            des_d[i] = rx_used && cdr_fast_tick[i];
            aln_d[i] = rx_used && cdr_slow_tick[i];
            rmw_d[i] = rx_used && rmf_q[i] && cdr_slow_tick[i];
            // Past the rate match FIFO the receive side runs on the transmit clock
            rx_base  = rmf_q[i] ? (rx_used && slow) : (rx_used && cdr_slow_tick[i]);
            rxp_d[i] = rx_base;
            rx_ph_d[i] = !live ? 1'b0 : (rx_base ? ~rx_ph_q[i] : rx_ph_q[i]);
            rxw_tk_d[i] = chan_clk_pkg::halve_tick(bdes_q[i], rx_base, rx_ph_q[i]);
            // Recovered clock exported only when it is the FIFO clock
            rxclk_d[i] = rxw_tk_d[i] && !rmf_q[i];
            ontx_d[i]  = rx_used && rmf_q[i];
            // Private pointers per channel
            rd_ptr_d[i] = !live ? 2'h0 : (txr_d[i] ? rd_ptr_q[i] + 2'h1 : rd_ptr_q[i]);
            wr_ptr_d[i] = !live ? 2'h0 : (rxw_tk_d[i] ? wr_ptr_q[i] + 2'h1 : wr_ptr_q[i]);
            seen_d[i] = txr_d[i] ? link.tx_word[i] : seen_q[i];
            rxw_d[i]  = rxw_tk_d[i] ? rx_data_in[i] : rxw_q[i];
        end
    end

    // Registers
    always_ff @(posedge clock) begin
        if (reset) begin
            pkg_q    <= chan_clk_pkg::rst_pkg;
            blk_q    <= 1'b0;
            mode_q   <= {n{chan_clk_pkg::rst_mode}};
            src_q    <= {n{chan_clk_pkg::rst_src}};
            bser_q   <= 4'h0;
            bdes_q   <= 4'h0;
            rmf_q    <= 4'h0;
            for (int i = 0; i < n; i++) begin
                state_q[i] <= chan_clk_pkg::st_config;
            end
            tx_ph_q  <= 4'h0;
            rx_ph_q  <= 4'h0;
            rd_ptr_q <= '0;
            wr_ptr_q <= '0;
            seen_q   <= '0;
            rxw_q    <= '0;
            ser_q    <= 4'h0;
            txp_q    <= 4'h0;
            txr_q    <= 4'h0;
            des_q    <= 4'h0;
            aln_q    <= 4'h0;
            rmw_q    <= 4'h0;
            rxp_q    <= 4'h0;
            rxw_tk_q <= 4'h0;
            rxclk_q  <= 4'h0;
            ontx_q   <= 4'h0;
            run_q    <= 4'h0;
            flt_q    <= 4'h0;
        end else begin
            pkg_q    <= pkg_d;
            blk_q    <= blk_d;
            mode_q   <= mode_d;
            src_q    <= src_d;
            bser_q   <= bser_d;
            bdes_q   <= bdes_d;
            rmf_q    <= rmf_d;
            for (int i = 0; i < n; i++) begin
                state_q[i] <= state_d[i];
            end
            tx_ph_q  <= tx_ph_d;
            rx_ph_q  <= rx_ph_d;
            rd_ptr_q <= rd_ptr_d;
            wr_ptr_q <= wr_ptr_d;
            seen_q   <= seen_d;
            rxw_q    <= rxw_d;
            ser_q    <= ser_d;
            txp_q    <= txp_d;
            txr_q    <= txr_d;
            des_q    <= des_d;
            aln_q    <= aln_d;
            rmw_q    <= rmw_d;
            rxp_q    <= rxp_d;
            rxw_tk_q <= rxw_tk_d;
            rxclk_q  <= rxclk_d;
            ontx_q   <= ontx_d;
            run_q    <= run_d;
            flt_q    <= flt_d;
        end
    end

    // Outputs straight from flops
    assign chan_running      = run_q;
    assign cfg_fault         = flt_q;
    assign ser_tick          = ser_q;
    assign tx_pcs_tick       = txp_q;
    assign tx_fifo_rd_tick   = txr_q;
    assign deser_tick        = des_q;
    assign align_tick        = aln_q;
    assign rmf_wr_tick       = rmw_q;
    assign rx_pcs_tick       = rxp_q;
    assign rx_fifo_wr_tick   = rxw_tk_q;
    assign tx_fifo_rd_ptr    = rd_ptr_q;
    assign rx_fifo_wr_ptr    = wr_ptr_q;
    assign tx_word_seen      = seen_q;
    assign link.tx_clkout    = txr_q;
    assign link.rx_clkout    = rxclk_q;
    assign link.rx_on_tx_clk = ontx_q;
    assign link.rx_word      = rxw_q;

endmodule : nonbonded_channel_clocking

// [src/fabric_channel_logic.sv]
`timescale 1ns/1ps
module fabric_channel_logic (
    input  wire logic            clock,
    input  wire logic            reset,
    chan_clk_if.fabric_end       link,
    input  wire logic [3:0][7:0] tx_data_in,
    output logic      [3:0]      tx_sent,
    output logic      [3:0][7:0] rx_data_out,
    output logic      [3:0]      rx_valid
);

    localparam int n = chan_clk_pkg::num_chan;

    logic [3:0][7:0] txw_q, txw_d;
    logic [3:0]      sent_q, sent_d;
    logic [3:0][7:0] rxd_q, rxd_d;
    logic [3:0]      val_q, val_d;

    // Launch on the exported transmit clock; capture on whichever clock owns the receive FIFO
    always_comb begin
        logic cap;
        cap = 1'b0;
        for (int i = 0; i < n; i++) begin
            sent_d[i] = link.tx_clkout[i];
            txw_d[i]  = link.tx_clkout[i] ? tx_data_in[i] : txw_q[i];
            // With rate match the recovered clock never reaches the fabric
            cap       = link.rx_on_tx_clk[i] ? link.tx_clkout[i] : link.rx_clkout[i];
            val_d[i]  = cap;
            rxd_d[i]  = cap ? link.rx_word[i] : rxd_q[i];
        end
    end

    // Registers
    always_ff @(posedge clock) begin
        if (reset) begin
            txw_q  <= '0;
            sent_q <= 4'h0;
            rxd_q  <= '0;
            val_q  <= 4'h0;
        end else begin
            txw_q  <= txw_d;
            sent_q <= sent_d;
            rxd_q  <= rxd_d;
            val_q  <= val_d;
        end
    end

    assign link.tx_word   = txw_q;
    assign link.tx_launch = sent_q;
    assign tx_sent        = sent_q;
    assign rx_data_out    = rxd_q;
    assign rx_valid       = val_q;

endmodule : fabric_channel_logic

// [testbench/chan_clk_monitor.sv]
`timescale 1ns/1ps
module chan_clk_monitor (
    input wire logic            clock,
    input wire logic            reset,
    input wire logic [3:0]      tx_clkout,
    input wire logic [3:0]      rx_clkout,
    input wire logic [3:0]      rx_on_tx_clk,
    input wire logic [3:0][7:0] rx_word,
    input wire logic [3:0][7:0] tx_word,
    input wire logic [3:0]      tx_launch
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    // Fabric launches exactly one cycle after each exported transmit tick
    a_launch_after_clk: assert property (!$past(reset) |-> tx_launch == $past(tx_clkout))
        else $error("launch does not follow tx_clkout");
    a_launch_idle: assert property ((tx_clkout == 4'h0) [*2] |-> tx_launch == 4'h0)
        else $error("launch without a transmit tick");
    // With rate matching the receive side rides the transmit clock, so rx_clkout stays dark
    a_rx_clk_gated: assert property ((rx_clkout & rx_on_tx_clk) == 4'h0)
        else $error("rx_clkout active with rate match");

    for (genvar i = 0; i < 4; i++) begin : g_lane
        // Words move only on the clock that the receiving end samples with
        a_rx_word_tick: assert property (
            $changed(rx_word[i]) |-> rx_clkout[i] || rx_on_tx_clk[i] || $past(rx_on_tx_clk[i]))
            else $error("rx_word moved off its clock");
        a_tx_word_launch: assert property ($changed(tx_word[i]) |-> tx_launch[i])
            else $error("tx_word moved without launch");
        a_launch_burst: assert property (
            tx_clkout[i] ##1 tx_clkout[i] |-> tx_launch[i] ##1 tx_launch[i])
            else $error("back-to-back ticks lost a launch");
        a_launch_ends: assert property ($fell(tx_clkout[i]) |-> tx_launch[i] ##1 !tx_launch[i])
            else $error("launch did not end with its tick");
        a_rmf_rx_quiet: assert property (
            $rose(rx_on_tx_clk[i]) |-> !rx_clkout[i] ##1 !rx_clkout[i])
            else $error("rx_clkout pulsed after rate match start");
    end

    // Main traffic kinds seen at the link
    c_tx_launch: cover property (tx_launch != 4'h0);
    c_rx_clk: cover property (rx_clkout != 4'h0);
    c_rmf_tx: cover property ((rx_on_tx_clk & tx_clkout) != 4'h0);
endmodule : chan_clk_monitor

// [testbench/testbench.sv]
`timescale 1ns/1ps
module testbench;
    logic            clock;
    logic            reset;
    logic [1:0]      cfg_pkg;
    logic            cfg_block;
    logic [3:0][1:0] cfg_mode;
    logic [3:0][2:0] cfg_src;
    logic [3:0]      cfg_byte_ser, cfg_byte_deser, cfg_rmf, cfg_load, run;
    logic [7:0]      pll_fast_tick, pll_slow_tick;
    logic [3:0]      cdr_fast_tick, cdr_slow_tick, tx_sent, rx_valid, chan_running, cfg_fault;
    logic [3:0]      ser_tick, tx_pcs_tick, tx_fifo_rd_tick, deser_tick, align_tick;
    logic [3:0]      rmf_wr_tick, rx_pcs_tick, rx_fifo_wr_tick;
    logic [3:0][1:0] tx_fifo_rd_ptr, rx_fifo_wr_ptr;
    logic [3:0][7:0] rx_data_in, tx_data_in, tx_word_seen, rx_data_out;
    int              n_mismatch = 0;
    int              checks = 0;

    chan_clk_if link ();
    nonbonded_channel_clocking i_nonbonded_channel_clocking (
        .clock, .reset, .link, .cfg_pkg, .cfg_block, .cfg_mode, .cfg_src, .cfg_byte_ser, .cfg_byte_deser,
        .cfg_rmf, .cfg_load, .run, .pll_fast_tick, .pll_slow_tick, .cdr_fast_tick, .cdr_slow_tick, .rx_data_in,
        .ser_tick, .tx_pcs_tick, .tx_fifo_rd_tick, .deser_tick, .align_tick, .rmf_wr_tick, .rx_pcs_tick,
        .rx_fifo_wr_tick, .tx_fifo_rd_ptr, .rx_fifo_wr_ptr, .tx_word_seen, .chan_running, .cfg_fault
    );
    fabric_channel_logic i_fabric_channel_logic (
        .clock, .reset, .link, .tx_data_in, .tx_sent, .rx_data_out, .rx_valid
    );
    chan_clk_monitor i_chan_clk_monitor (
        .clock, .reset, .tx_clkout(link.tx_clkout), .rx_clkout(link.rx_clkout), .rx_on_tx_clk(link.rx_on_tx_clk),
        .rx_word(link.rx_word), .tx_word(link.tx_word), .tx_launch(link.tx_launch)
    );

    // Free-running 40 MHz system clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Inputs always move 1 ns after the edge so sampling never races
    task automatic step();
        @(posedge clock);
        #1;
    endtask : step

    // Load then run: the run request must come in the cycle after the load
    task automatic start(input int ch, input logic [1:0] m, input logic [2:0] s, input logic [2:0] en);
        cfg_mode[ch] = m;
        cfg_src[ch] = s;
        {cfg_byte_ser[ch], cfg_byte_deser[ch], cfg_rmf[ch]} = en;
        cfg_load[ch] = 1'b1;
        step();
        cfg_load[ch] = 1'b0;
        run[ch] = 1'b1;
        step();
    endtask : start

    task automatic stop();
        run = 4'h0;
        step();
    endtask : stop

    // One-cycle tick burst; the leading idle cycle keeps drives apart in time
    task automatic pulse(input logic [7:0] f, input logic [7:0] s, input logic [3:0] cf, input logic [3:0] cs);
        step();
        {pll_fast_tick, pll_slow_tick, cdr_fast_tick, cdr_slow_tick} = {f, s, cf, cs};
        step();
        {pll_fast_tick, pll_slow_tick, cdr_fast_tick, cdr_slow_tick} = 24'h0;
    endtask : pulse

    task automatic test_tx();
        cfg_pkg = chan_clk_pkg::pkg_small;
        cfg_block = 1'b0;
        tx_data_in[0] = 8'h5a;
        start(0, chan_clk_pkg::mode_tx_only, chan_clk_pkg::src_adjacent_pll_b_small_pkg, 3'h0);
        start(1, chan_clk_pkg::mode_tx_only, chan_clk_pkg::src_adjacent_pll_a_small_pkg, 3'h4);
        chk(chan_running, 4'h3);
        pulse(8'h02, 8'h02, 4'h0, 4'h0);
        chk(ser_tick, 4'h1);
        chk(tx_pcs_tick & tx_fifo_rd_tick, 4'h1);
        chk(link.tx_clkout, 4'h1);
        chk(tx_fifo_rd_ptr, 8'h01);
        step();
        chk(tx_sent, 4'h1);
        chk(link.tx_word[0], 8'h5a);
        pulse(8'h01, 8'h01, 4'h0, 4'h0);
        chk(tx_pcs_tick, 4'h2);
        chk(tx_fifo_rd_tick, 4'h0);
        pulse(8'h01, 8'h01, 4'h0, 4'h0);
        chk(tx_fifo_rd_tick, 4'h2);
        pulse(8'h02, 8'h02, 4'h0, 4'h0);
        chk(tx_word_seen[0], 8'h5a);
        stop();
        $display("test_tx done");
    endtask : test_tx

    // Refused pairings fault; loads while running are ignored
    task automatic test_fault();
        start(2, chan_clk_pkg::mode_tx_only, chan_clk_pkg::src_general_pll_one, 3'h0);
        start(3, 2'h3, chan_clk_pkg::src_adjacent_pll_a_small_pkg, 3'h0);
        chk(cfg_fault, 4'hc);
        stop();
        start(2, chan_clk_pkg::mode_rx_only, 3'h0, 3'h1);
        chk(cfg_fault, 4'h4);
        cfg_pkg = chan_clk_pkg::pkg_f484;
        cfg_block = 1'b1;
        start(3, chan_clk_pkg::mode_tx_only, chan_clk_pkg::src_adjacent_pll_a_block1, 3'h0);
        chk(cfg_fault, 4'hc);
        stop();
        pulse(8'hff, 8'hff, 4'hf, 4'hf);
        chk(tx_pcs_tick | align_tick, 4'h0);
        cfg_pkg = chan_clk_pkg::pkg_large;
        start(3, chan_clk_pkg::mode_tx_only, chan_clk_pkg::src_general_pll_two, 3'h0);
        chk(chan_running, 4'h8);
        cfg_src[3] = 3'h0;
        cfg_load[3] = 1'b1;
        pulse(8'h80, 8'h80, 4'h0, 4'h0);
        chk(tx_pcs_tick & ser_tick, 4'h8);
        cfg_load[3] = 1'b0;
        stop();
        $display("test_fault done");
    endtask : test_fault

    task automatic test_rx();
        rx_data_in[2] = 8'hc3;
        start(2, chan_clk_pkg::mode_rx_only, 3'h0, 3'h2);
        pulse(8'h00, 8'h00, 4'h4, 4'h4);
        chk(deser_tick, 4'h4);
        chk(align_tick & rx_pcs_tick, 4'h4);
        chk(rx_fifo_wr_tick, 4'h0);
        pulse(8'h00, 8'h00, 4'h4, 4'h4);
        chk(link.rx_clkout, 4'h4);
        chk(link.rx_word[2], 8'hc3);
        chk(rx_fifo_wr_ptr, 8'h10);
        step();
        chk(rx_valid, 4'h4);
        chk(rx_data_out[2], 8'hc3);
        stop();
        $display("test_rx done");
    endtask : test_rx

    // Rate match: receive PCS moves to the transmit clock, halved by the byte deserializer for the FIFO write
    task automatic test_rmf();
        cfg_pkg = chan_clk_pkg::pkg_small;
        cfg_block = 1'b0;
        rx_data_in[0] = 8'h3c;
        start(0, chan_clk_pkg::mode_tx_rx, chan_clk_pkg::src_adjacent_pll_a_small_pkg, 3'h3);
        // The rate match flag is registered from the run state, one cycle behind it
        step();
        chk(link.rx_on_tx_clk, 4'h1);
        pulse(8'h00, 8'h00, 4'h1, 4'h1);
        chk(align_tick & rmf_wr_tick, 4'h1);
        chk(rx_pcs_tick, 4'h0);
        pulse(8'h01, 8'h01, 4'h0, 4'h0);
        chk(rx_pcs_tick & link.tx_clkout, 4'h1);
        chk(rx_fifo_wr_tick, 4'h0);
        pulse(8'h01, 8'h01, 4'h0, 4'h0);
        chk(rx_fifo_wr_tick, 4'h1);
        chk(link.rx_clkout, 4'h0);
        step();
        chk(rx_valid, 4'h1);
        chk(rx_data_out[0], 8'h3c);
        stop();
        $display("test_rmf done");
    endtask : test_rmf

    // Hang guard far beyond the 62 cycles the run needs
    initial begin
        #100000;
        n_mismatch++;
        end_sim();
    end

    // Main sequence
    initial begin
        reset = 1'b1;
        {cfg_pkg, cfg_block, cfg_mode, cfg_src, cfg_byte_ser, cfg_byte_deser, cfg_rmf, cfg_load, run} = '0;
        {pll_fast_tick, pll_slow_tick, cdr_fast_tick, cdr_slow_tick, rx_data_in, tx_data_in} = '0;
        repeat (12) step();
        reset = 1'b0;
        test_tx();
        test_fault();
        test_rx();
        test_rmf();
        end_sim();
    end
endmodule : testbench
